// [verilog/cqc_channel_ctl.sv]
// Register file, establish sequencer, wake and send control for both line channels.
//
// Strobed register access was chosen for this implementation.
`include "cqc_consts.svh"
module cqc_channel_ctl #(
   parameter int WAKE_CYC = `CQC_WAKE_CYC,
   parameter int REPLY_CYC = `CQC_REPLY_CYC
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic wr_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic irq_out,
   input wire logic [1:0] reply_ok_in,
   input wire logic [1:0][7:0] reply_period_in,
   input wire logic [1:0] tx_empty_in,
   input wire logic [1:0] trig_in,
   output logic [1:0] wake_drive_out,
   output logic [1:0] cur_boost_out,
   output logic [1:0] tx_mode_out,
   output logic [1:0] send_start_out,
   output logic [1:0] probe_out,
   output cqc_pkg::cqc_rate_t [1:0] probe_rate_out,
   output logic [1:0][15:0] line_baud_div_out,
   output logic [1:0] tx_queue_clear_out,
   output logic [1:0] rx_queue_clear_out
);
   import cqc_pkg::*;

   cqc_state_t q;
   cqc_state_t d;
   logic [1:0] expire;
   logic [1:0] tmr_start;

   // Failure code 00 runs at the top rate so the line stays usable.
   function automatic logic [15:0] rate_div(input cqc_rate_t rate);
      case (rate)
         2'h1: rate_div = `CQC_DIV_COM1; // see RULE6
         2'h2: rate_div = `CQC_DIV_COM2; // see RULE6
         default: rate_div = `CQC_DIV_COM3; // see RULE6
      endcase
   endfunction : rate_div

   function automatic logic is_ctrl_wr(input logic wr, input logic [7:0] addr, input int ch);
      is_ctrl_wr = wr && (addr == ((ch == 0) ? `CQC_ADDR_CTRL_A : `CQC_ADDR_CTRL_B));
   endfunction : is_ctrl_wr

   // The timer starts on a send write or a trigger, only while armed.
   always_comb begin
      for (int i = 0; i < 2; i++) begin
         tmr_start[i] = trig_in[i] || (is_ctrl_wr(wr_in, addr_in, i)
                        && wdata_in[`CQC_BIT_SEND] && q.seq[i] == CQC_IDLE); // see RULE14
      end
   end

   generate
      for (genvar g = 0; g < 2; g++) begin : gen_tmr
         cqc_period_timer u_tmr (
            .clock_in(clock_in),
            .rst_in(rst_in),
            .arm_in(q.ctrl[g][`CQC_BIT_TMR]), // see RULE11
            .start_in(tmr_start[g]),
            .tick_in(q.tick),
            .period_in(q.master_period[g]),
            .expire_out(expire[g])
         );
      end
   endgenerate

   always_comb begin
      logic wake_set;
      logic ch_wr;
      wake_set = 1'b0;
      ch_wr = 1'b0;
      d = q;
      d.send_start = '0;
      d.probe = '0;
      d.tx_clr = '0;
      d.rx_clr = '0;
      d.rdata = 8'h00;
      d.tick = 1'b0;
      if (q.tick_cnt == `CQC_TICK_CYC - 8'h01) begin
         d.tick_cnt = 8'h00;
         d.tick = 1'b1;
      end else begin
         d.tick_cnt = q.tick_cnt + 8'h01;
      end

      // Each channel touches only its own slice of the state, except the shared wake_set.
      for (int i = 0; i < 2; i++) begin // see RULE17
         ch_wr = is_ctrl_wr(wr_in, addr_in, i); // see RULE15
         d.ctrl[i][`CQC_BIT_SEND] = 1'b0; // see RULE14
         if (ch_wr) begin
            d.ctrl[i][`CQC_BIT_TXCLR] = wdata_in[`CQC_BIT_TXCLR];
            d.ctrl[i][`CQC_BIT_RXCLR] = wdata_in[`CQC_BIT_RXCLR];
            d.ctrl[i][`CQC_BIT_TMR] = wdata_in[`CQC_BIT_TMR]; // see RULE11
            d.tx_clr[i] = wdata_in[`CQC_BIT_TXCLR]; // see RULE9
            d.rx_clr[i] = wdata_in[`CQC_BIT_RXCLR]; // see RULE10
            // A busy sequencer owns the rate, establish and wake bits.
            if (q.seq[i] == CQC_IDLE) begin
               d.ctrl[i][7:6] = wdata_in[7:6];
               if (wdata_in[`CQC_BIT_EST]) begin
                  d.ctrl[i][`CQC_BIT_EST] = 1'b1; // see RULE1
                  d.seq[i] = CQC_WAKE;
                  d.auto_seq[i] = 1'b1;
                  d.cnt[i] = 16'h0000;
                  d.wake_drive[i] = 1'b1;
                  d.cur_boost[i] = 1'b1; // see RULE2
                  d.tx_mode[i] = 1'b1;
               end else if (wdata_in[`CQC_BIT_WAKE]) begin
                  d.ctrl[i][`CQC_BIT_WAKE] = 1'b1; // see RULE7
                  d.seq[i] = CQC_WAKE;
                  d.auto_seq[i] = 1'b0;
                  d.cnt[i] = 16'h0000;
                  d.wake_drive[i] = 1'b1;
                  d.tx_mode[i] = 1'b1;
               end else if (wdata_in[`CQC_BIT_SEND]) begin
                  d.ctrl[i][`CQC_BIT_SEND] = 1'b1; // see RULE13
                  d.send_start[i] = 1'b1;
                  d.tx_mode[i] = 1'b1;
               end
            end
         end
         if (expire[i] && q.seq[i] == CQC_IDLE && !d.send_start[i]) begin
            d.send_start[i] = 1'b1;
            d.tx_mode[i] = 1'b1;
         end
         // The framer needs one cycle to pull the first byte, so an empty flag
         // right at the send strobe does not end the message.
         if (q.seq[i] == CQC_IDLE && q.tx_mode[i] && tx_empty_in[i]
             && !q.send_start[i] && !d.send_start[i]) begin
            d.tx_mode[i] = 1'b0; // see RULE13
         end

         case (q.seq[i])
            CQC_IDLE: begin
            end
            CQC_WAKE: begin
               d.cnt[i] = q.cnt[i] + 16'h0001;
               if (q.cnt[i] == 16'(WAKE_CYC - 1)) begin
                  d.wake_drive[i] = 1'b0;
                  d.cur_boost[i] = 1'b0; // see RULE2
                  d.tx_mode[i] = 1'b0; // see RULE7
                  d.cnt[i] = 16'h0000;
                  if (q.auto_seq[i]) begin
                     d.seq[i] = CQC_PROBE;
                     d.try_rate[i] = 2'h3;
                  end else begin
                     d.seq[i] = CQC_IDLE;
                     d.ctrl[i][`CQC_BIT_WAKE] = 1'b0; // see RULE7
                     wake_set = 1'b1;
                  end
               end
            end
            CQC_PROBE: begin
               d.probe[i] = 1'b1;
               d.cnt[i] = 16'h0000;
               d.seq[i] = CQC_LISTEN;
            end
            CQC_LISTEN: begin
               d.cnt[i] = q.cnt[i] + 16'h0001;
               if (reply_ok_in[i]) begin
                  d.ctrl[i][7:6] = q.try_rate[i]; // see RULE3
                  d.remote_period[i] = reply_period_in[i]; // see RULE3
                  d.ctrl[i][`CQC_BIT_EST] = 1'b0; // see RULE1
                  d.seq[i] = CQC_IDLE;
                  wake_set = 1'b1; // see RULE1
               end else if (q.cnt[i] == 16'(REPLY_CYC - 1)) begin
                  // Slowest rate is tried last; silence there ends the search.
                  if (q.try_rate[i] == 2'h1) begin
                     d.ctrl[i][7:6] = 2'h0; // see RULE4
                     d.ctrl[i][`CQC_BIT_EST] = 1'b0; // see RULE4
                     d.seq[i] = CQC_IDLE;
                     wake_set = 1'b1; // see RULE4
                  end else begin
                     d.try_rate[i] = q.try_rate[i] - 2'h1;
                     d.seq[i] = CQC_PROBE;
                  end
               end
            end
            default: begin
               d.seq[i] = CQC_IDLE;
            end
         endcase
         d.baud_div[i] = rate_div((d.seq[i] == CQC_IDLE) ? d.ctrl[i][7:6] : d.try_rate[i]);
      end

      if (wr_in) begin
         case (addr_in)
            `CQC_ADDR_IRQ_EN: d.irq_en = wdata_in;
            `CQC_ADDR_MPERIOD_A: d.master_period[0] = wdata_in;
            `CQC_ADDR_MPERIOD_B: d.master_period[1] = wdata_in;
            `CQC_ADDR_FRAMER: d.framer_on = wdata_in[1:0];
            default: begin
            end
         endcase
      end

      if (rd_in) begin
         case (addr_in)
            `CQC_ADDR_IRQ_EN: d.rdata = q.irq_en;
            `CQC_ADDR_CTRL_A: d.rdata = q.ctrl[0];
            `CQC_ADDR_CTRL_B: d.rdata = q.ctrl[1];
            `CQC_ADDR_PERIOD_A: d.rdata = q.remote_period[0];
            `CQC_ADDR_PERIOD_B: d.rdata = q.remote_period[1];
            `CQC_ADDR_MPERIOD_A: d.rdata = q.master_period[0];
            `CQC_ADDR_MPERIOD_B: d.rdata = q.master_period[1];
            `CQC_ADDR_FRAMER: d.rdata = {6'h00, q.framer_on};
            `CQC_ADDR_STATUS: d.rdata = {1'b0, q.wake_flag, 6'h00};
            default: d.rdata = 8'h00;
         endcase
      end

      // Clear on read, but a new event in the same cycle survives.
      d.wake_flag = (q.wake_flag && !(rd_in && addr_in == `CQC_ADDR_STATUS)) || wake_set;
      d.irq = d.wake_flag && d.irq_en[`CQC_BIT_WAKE_IRQ]; // see RULE16
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '0;
         q.ctrl[0] <= `CQC_CTRL_RST;
         q.ctrl[1] <= `CQC_CTRL_RST;
         q.irq_en <= `CQC_IRQ_EN_RST;
         q.master_period <= {2{`CQC_PERIOD_RST}};
         q.baud_div <= {2{`CQC_DIV_COM3}};
      end else begin
         q <= d;
      end
   end

   assign rdata_out = q.rdata;
   assign irq_out = q.irq;
   assign wake_drive_out = q.wake_drive;
   assign cur_boost_out = q.cur_boost;
   assign tx_mode_out = q.tx_mode;
   assign send_start_out = q.send_start;
   assign probe_out = q.probe;
   assign probe_rate_out = q.try_rate;
   assign line_baud_div_out = q.baud_div;
   assign tx_queue_clear_out = q.tx_clr;
   assign rx_queue_clear_out = q.rx_clr;

   default clocking ctl_cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   est_start_a: assert property ( // see RULE1
      wr_in && addr_in == `CQC_ADDR_CTRL_A && wdata_in[`CQC_BIT_EST] && q.seq[0] == CQC_IDLE
      |=> wake_drive_out[0] && cur_boost_out[0] && q.ctrl[0][`CQC_BIT_EST])
      else $error("establish write did not start the wake pulse");
   boost_wake_a: assert property (cur_boost_out[0] |-> wake_drive_out[0]) // see RULE2
      else $error("current boost outside the wake pulse");
   est_result_a: assert property ( // see RULE3
      q.seq[0] == CQC_LISTEN && reply_ok_in[0]
      |=> q.ctrl[0][7:6] == $past(q.try_rate[0]) && q.remote_period[0] == $past(reply_period_in[0])
      ##0 !q.ctrl[0][`CQC_BIT_EST])
      else $error("detected rate or remote period not stored");
   est_fail_a: assert property ( // see RULE4
      q.seq[0] == CQC_LISTEN && !reply_ok_in[0] && q.try_rate[0] == 2'h1
      && q.cnt[0] == 16'(REPLY_CYC - 1) && !(rd_in && addr_in == `CQC_ADDR_STATUS)
      |=> q.ctrl[0][7:6] == 2'h0 && !q.ctrl[0][`CQC_BIT_EST] && q.wake_flag)
      else $error("failed establish not reported");
   fail_rate_a: assert property ( // see RULE6
      q.seq[1] == CQC_IDLE && q.ctrl[1][7:6] == 2'h0 |-> line_baud_div_out[1] == `CQC_DIV_COM3)
      else $error("failure rate code not at top bit rate");
   wake_end_a: assert property ( // see RULE7
      $fell(wake_drive_out[0]) && !q.auto_seq[0]
      |-> !tx_mode_out[0] && !q.ctrl[0][`CQC_BIT_WAKE] && q.wake_flag)
      else $error("manual wake did not return to receive");
   send_pulse_a: assert property ( // see RULE13
      wr_in && addr_in == `CQC_ADDR_CTRL_A && wdata_in == 8'h01 && q.seq[0] == CQC_IDLE
      |=> send_start_out[0] && tx_mode_out[0] ##1 !q.ctrl[0][`CQC_BIT_SEND])
      else $error("send write did not start transmit or self clear");
   queue_clr_a: assert property ( // see RULE9
      wr_in && addr_in == `CQC_ADDR_CTRL_B && wdata_in[`CQC_BIT_TXCLR] && wdata_in[`CQC_BIT_RXCLR]
      |=> tx_queue_clear_out[1] && rx_queue_clear_out[1] && !tx_queue_clear_out[0])
      else $error("queue clear not issued on channel B alone");
   irq_mask_a: assert property (!q.irq_en[`CQC_BIT_WAKE_IRQ] [*2] |-> !irq_out) // see RULE16
      else $error("interrupt output raised while masked");
   chan_iso_a: assert property ( // see RULE17
      wr_in && addr_in == `CQC_ADDR_CTRL_A && q.seq[1] == CQC_IDLE
      |=> q.ctrl[1][7:1] == $past(q.ctrl[1][7:1]))
      else $error("channel A write disturbed channel B");

   est_ok_c: cover property (q.seq[0] == CQC_LISTEN && reply_ok_in[0]);
   est_fail_c: cover property (q.seq[1] == CQC_LISTEN && q.try_rate[1] == 2'h1
      && q.cnt[1] == 16'(REPLY_CYC - 1) && !reply_ok_in[1]);
   auto_send_c: cover property (expire[0] && send_start_out[0] == 1'b0 ##1 send_start_out[0]);
   irq_c: cover property ($rose(irq_out));
endmodule : cqc_channel_ctl

// [verilog/cqc_consts.svh]
// Constants for the per-channel line control block.
// What the document requires
// RULE1: Writing 1 to a channel's establish bit starts the automatic wake and rate detection, and success raises the wake interrupt and clears the bit.
// RULE2: While the sequencer drives its wake pulse the line current limit is boosted internally, and the software current-limit bits stay as they are.
// The code boosts only in the establish wake pulse, not in a manual wake.
// RULE3: After a successful establish sequence the detected rate goes into the rate field and the remote cycle time becomes readable.
// RULE4: A failed establish sequence still raises the wake interrupt, clears the establish bit and forces the rate field to 00.
// RULE5: The host sets the channel's framer enable to 1 before it uses the establish sequence.
// RULE6: The rate field selects 4.8 kbps for 01, 38.4 kbps for 10, 230.4 kbps for 11, and 00 marks a failure and runs at 230.4 kbps.
// RULE7: Writing 1 to the wake bit emits one wake request at once, then the line goes to receive and the bit clears when the request ends.
// RULE8: The host uses the manual wake bit only when it runs connection setup itself.
// RULE9: Setting the transmit-queue clear bit empties that channel's transmit queue.
// RULE10: Setting the receive-queue clear bit empties that channel's receive queue.
// RULE11: Setting the timer enable only arms the cycle timer, which starts on a later send or a trigger command.
// RULE12: Clearing the timer enable stops the cycle timer at once, even mid-cycle.
// RULE13: Writing 1 to the send bit puts the line in transmit and sends the queued master message, then returns to receive when the queue is empty.
// RULE14: A send write also starts the cycle timer when it is enabled, and the send bit clears itself.
// RULE15: Channel B has its own control register laid out like channel A's, all bits 0 at reset.
// RULE16: The wake interrupt reaches the interrupt output only while bit 6 of the interrupt enable register is 1.
// RULE17: The two channels run independently so that a write to one never disturbs the other.
`ifndef CQC_CONSTS_SVH
`define CQC_CONSTS_SVH
`define CQC_ADDR_IRQ_EN 8'h03
`define CQC_ADDR_CTRL_A 8'h06
`define CQC_ADDR_CTRL_B 8'h07
`define CQC_ADDR_PERIOD_A 8'h10
`define CQC_ADDR_PERIOD_B 8'h11
`define CQC_ADDR_MPERIOD_A 8'h12
`define CQC_ADDR_MPERIOD_B 8'h13
`define CQC_ADDR_FRAMER 8'h14
`define CQC_ADDR_STATUS 8'h15
`define CQC_BIT_SEND 0
`define CQC_BIT_TMR 1
`define CQC_BIT_RXCLR 2
`define CQC_BIT_TXCLR 3
`define CQC_BIT_WAKE 4
`define CQC_BIT_EST 5
`define CQC_BIT_WAKE_IRQ 6
`define CQC_CTRL_RST 8'h00
`define CQC_IRQ_EN_RST 8'h00
`define CQC_PERIOD_RST 8'h00
`define CQC_CLK_NS 4
`define CQC_CLK_HZ 250000000
`define CQC_BPS_COM1 4800
`define CQC_BPS_COM2 38400
`define CQC_BPS_COM3 230400
`define CQC_DIV_COM1 16'(`CQC_CLK_HZ / `CQC_BPS_COM1)
`define CQC_DIV_COM2 16'(`CQC_CLK_HZ / `CQC_BPS_COM2)
`define CQC_DIV_COM3 16'(`CQC_CLK_HZ / `CQC_BPS_COM3)
`define CQC_WAKE_NS 80000
`define CQC_WAKE_CYC ((`CQC_WAKE_NS + `CQC_CLK_NS - 1) / `CQC_CLK_NS)
`define CQC_REPLY_NS 100000
`define CQC_REPLY_CYC ((`CQC_REPLY_NS + `CQC_CLK_NS - 1) / `CQC_CLK_NS)
`define CQC_TICK_NS 1000
`define CQC_TICK_CYC 8'((`CQC_TICK_NS + `CQC_CLK_NS - 1) / `CQC_CLK_NS)
`endif

// [verilog/cqc_pkg.sv]
// Types shared by the line control block and its cycle timer.
package cqc_pkg;
   typedef enum logic [1:0] {CQC_IDLE, CQC_WAKE, CQC_PROBE, CQC_LISTEN} cqc_seq_t;
   typedef logic [1:0] cqc_rate_t;
   typedef struct packed {
      logic running;
      logic [7:0] count;
      logic expire;
   } cqc_timer_t;
   typedef struct packed {
      logic [1:0][7:0] ctrl;
      logic [7:0] irq_en;
      logic [1:0] framer_on;
      logic [1:0][7:0] remote_period;
      logic [1:0][7:0] master_period;
      logic wake_flag;
      cqc_seq_t [1:0] seq;
      logic [1:0] auto_seq;
      logic [1:0][15:0] cnt;
      cqc_rate_t [1:0] try_rate;
      logic [1:0] tx_mode;
      logic [1:0] wake_drive;
      logic [1:0] cur_boost;
      logic [1:0] send_start;
      logic [1:0] probe;
      logic [1:0] tx_clr;
      logic [1:0] rx_clr;
      logic [1:0][15:0] baud_div;
      logic [7:0] tick_cnt;
      logic tick;
      logic [7:0] rdata;
      logic irq;
   } cqc_state_t;
endpackage : cqc_pkg

// [verilog/cqc_period_timer.sv]
// Autonomous cycle timer for one line channel.
`include "cqc_consts.svh"
module cqc_period_timer (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic arm_in,
   input wire logic start_in,
   input wire logic tick_in,
   input wire logic [7:0] period_in,
   output logic expire_out
);
   import cqc_pkg::*;
   cqc_timer_t q;
   cqc_timer_t d;

   always_comb begin
      d = q;
      d.expire = 1'b0;
      if (!arm_in) begin
         // Disarming kills a cycle in flight; no expiry may follow it.
         d.running = 1'b0; // see RULE12
         d.count = 8'h00;
      end else if (!q.running) begin
         if (start_in) begin
            d.running = 1'b1; // see RULE11
            d.count = period_in;
         end
      end else if (tick_in) begin
         if (q.count <= 8'h01) begin
            d.expire = 1'b1;
            d.count = period_in;
         end else begin
            d.count = q.count - 8'h01;
         end
      end
   end

   always_ff @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign expire_out = q.expire;

   default clocking tmr_cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);

   disarm_stops_a: assert property (!arm_in |=> !q.running && !expire_out) // see RULE12
      else $error("cycle timer still running after disarm");
   arm_only_a: assert property (arm_in && !q.running && !start_in |=> !q.running) // see RULE11
      else $error("cycle timer started without send or trigger");
endmodule : cqc_period_timer

// [dv/cqc_line_device.sv]
// Behavioural field device that answers establish probes at one line rate.
module cqc_line_device (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic probe_in,
   input wire logic [1:0] probe_rate_in,
   input wire logic [1:0] own_rate_in,
   input wire logic [3:0] delay_in,
   input wire logic [7:0] own_period_in,
   output logic reply_ok_out,
   output logic [7:0] reply_period_out
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_q;
   // Outside a reply the period lines toggle, so a design that samples them late sees garbage.
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         wait_q <= 0;
         reply_ok_out <= 1'b0;
         reply_period_out <= 8'h00;
      end else begin
         reply_ok_out <= 1'b0;
         reply_period_out <= ~reply_period_out;
         if (probe_in && own_rate_in != 2'h0 && probe_rate_in == own_rate_in) begin
            wait_q <= int'(delay_in);
         end else if (wait_q > 1) begin
            wait_q <= wait_q - 1;
         end else if (wait_q == 1) begin
            wait_q <= 0;
            reply_ok_out <= 1'b1;
            reply_period_out <= own_period_in;
         end
      end
   end
endmodule : cqc_line_device

// [dv/test_cqc_channel_ctl.sv]
// Self-checking bench for the line control block with a field device on each channel.
`include "cqc_consts.svh"
module test_cqc_channel_ctl;
   timeunit 1ns;
   timeprecision 1ps;
   import cqc_pkg::*;
   localparam int WAKE = 8;
   localparam int LIMIT = 10000;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic [7:0] addr_in = 8'h00;
   logic [7:0] wdata_in = 8'h00;
   logic wr_in = 1'b0;
   logic rd_in = 1'b0;
   logic [7:0] rdata_out;
   logic irq_out;
   logic [1:0] reply_ok;
   logic [1:0][7:0] reply_period;
   logic [1:0] tx_empty = 2'h3;
   logic [1:0] trig = 2'h0;
   logic [1:0] wake_drive, cur_boost, tx_mode, send_start, probe, txc, rxc;
   cqc_rate_t [1:0] probe_rate;
   logic [1:0][15:0] baud_div;
   logic [1:0][1:0] dev_rate = '0;
   logic [1:0][3:0] dev_delay = '0;
   logic [1:0][7:0] dev_period = '0;
   logic [1:0][7:0] ctrl_m = '0;
   int failures = 0;
   int checks = 0;
   int cycles = 0;
   int wakes [2];
   int boosts [2];
   int probes [2];
   int starts [2];
   int seed = 32'h52279703;
   always #2 clock_in = ~clock_in;
   cqc_channel_ctl #(.WAKE_CYC(WAKE), .REPLY_CYC(16)) cqc_channel_ctl_inst (
      .clock_in(clock_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .irq_out(irq_out),
      .reply_ok_in(reply_ok), .reply_period_in(reply_period), .tx_empty_in(tx_empty),
      .trig_in(trig), .wake_drive_out(wake_drive), .cur_boost_out(cur_boost),
      .tx_mode_out(tx_mode), .send_start_out(send_start), .probe_out(probe),
      .probe_rate_out(probe_rate), .line_baud_div_out(baud_div),
      .tx_queue_clear_out(txc), .rx_queue_clear_out(rxc));
   for (genvar g = 0; g < 2; g++) begin : dev
      cqc_line_device cqc_line_device_inst (
         .clock_in(clock_in), .rst_in(rst_in), .probe_in(probe[g]),
         .probe_rate_in(probe_rate[g]), .own_rate_in(dev_rate[g]), .delay_in(dev_delay[g]),
         .own_period_in(dev_period[g]), .reply_ok_out(reply_ok[g]),
         .reply_period_out(reply_period[g]));
   end
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      for (int c = 0; c < 2; c++) begin
         wakes[c] <= wakes[c] + int'(wake_drive[c] === 1'b1);
         boosts[c] <= boosts[c] + int'(cur_boost[c] === 1'b1);
         probes[c] <= probes[c] + int'(probe[c] === 1'b1);
         starts[c] <= starts[c] + int'(send_start[c] === 1'b1);
      end
      if (cycles == LIMIT) begin
         failures++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("Checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s read %h expected %h", $time, what, got, exp);
      end
   endtask : chk_reg
   task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: %s is %0d expected %0d", $time, what, got, exp);
      end
   endtask : chk_val
   function automatic logic [7:0] ctl(input int ch);
      return 8'(`CQC_ADDR_CTRL_A + ch);
   endfunction : ctl
   function automatic int exp_div(input int r);
      case (r)
         1: return 250000000 / 4800;
         2: return 250000000 / 38400;
         default: return 250000000 / 230400;
      endcase
   endfunction : exp_div
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clock_in);
      wr_in <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clock_in);
      rd_in <= 1'b0;
      #1 d = rdata_out;
   endtask : rd
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic [7:0] d;
      rd(a, d);
      chk_reg(d, exp, what);
   endtask : rdchk
   task automatic wait_clear(input int ch, input logic [7:0] m);
      logic [7:0] d;
      d = m;
      for (int i = 0; i < 80 && (d & m) != 8'h00; i++) rd(ctl(ch), d);
      chk_reg(d & m, 8'h00, "self clearing bit");
   endtask : wait_clear
   task automatic zero_counts();
      @(negedge clock_in);
      wakes = '{0, 0};
      boosts = '{0, 0};
      probes = '{0, 0};
      starts = '{0, 0};
   endtask : zero_counts
   task automatic settle(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask : settle
   task automatic irq_walk();
      chk_val(16'(irq_out), 16'h0, "masked irq");
      wr(`CQC_ADDR_IRQ_EN, 8'h40);
      settle(2);
      chk_val(16'(irq_out), 16'h1, "enabled irq");
      rdchk(`CQC_ADDR_STATUS, 8'h40, "status");
      settle(2);
      chk_val(16'(irq_out), 16'h0, "irq after status read");
      wr(`CQC_ADDR_IRQ_EN, 8'h00);
   endtask : irq_walk
   initial begin
      int rates [4] = '{3, 2, 1, 0};
      logic [7:0] rv;
      repeat (8) @(posedge clock_in);
      rst_in <= 1'b0;
      #1 chk_val(baud_div[0], 16'(exp_div(0)), "reset divider a");
      chk_val(baud_div[1], 16'(exp_div(0)), "reset divider b");
      rdchk(ctl(0), 8'h00, "reset ctrl a");
      rdchk(ctl(1), 8'h00, "reset ctrl b");
      rdchk(`CQC_ADDR_STATUS, 8'h00, "reset status");
      wr(8'h3F, 8'hFF);
      rdchk(8'h3F, 8'h00, "unmapped");
      for (int i = 0; i < 6; i++) begin
         rv = 8'($random(seed)) & 8'h0E;
         wr(ctl(i % 2), rv);
         #1 chk_val(16'(txc), 16'(2'(rv[3]) << (i % 2)), "tx clear");
         chk_val(16'(rxc), 16'(2'(rv[2]) << (i % 2)), "rx clear");
         ctrl_m[i % 2] = rv;
         rdchk(ctl(0), ctrl_m[0], "ctrl a");
         rdchk(ctl(1), ctrl_m[1], "ctrl b");
      end
      wr(ctl(0), 8'h00);
      wr(ctl(1), 8'h00);
      tx_empty <= 2'h2;
      wr(ctl(0), 8'h01);
      #1 chk_val(16'(send_start), 16'h1, "send pulse");
      chk_val(16'(tx_mode), 16'h1, "transmit mode");
      settle(3);
      chk_val(16'(tx_mode), 16'h1, "transmit held");
      @(posedge clock_in);
      tx_empty <= 2'h3;
      settle(3);
      chk_val(16'(tx_mode), 16'h0, "receive after empty");
      rdchk(ctl(0), 8'h00, "send cleared");
      wr(`CQC_ADDR_MPERIOD_A, 8'h01);
      wr(ctl(0), 8'h02);
      zero_counts();
      settle(600);
      chk_val(16'(starts[0]), 16'h0, "armed only");
      @(posedge clock_in);
      trig <= 2'h1;
      @(posedge clock_in);
      trig <= 2'h0;
      settle(1000);
      chk_val(16'(starts[0] >= 3 && starts[0] <= 5), 16'h1, "trigger start");
      wr(ctl(0), 8'h00);
      zero_counts();
      settle(600);
      chk_val(16'(starts[0]), 16'h0, "timer stopped");
      wr(ctl(0), 8'h02);
      wr(ctl(0), 8'h03);
      zero_counts();
      settle(600);
      chk_val(16'(starts[0] >= 2), 16'h1, "send starts timer");
      wr(ctl(0), 8'h00);
      wr(`CQC_ADDR_FRAMER, 8'h03);
      for (int ch = 0; ch < 2; ch++) begin
         for (int k = 0; k < 4; k++) begin
            dev_rate[ch] <= 2'(rates[k]);
            dev_delay[ch] <= 4'(1 + ($unsigned($random(seed)) % 12));
            dev_period[ch] <= 8'($random(seed));
            zero_counts();
            wr(ctl(ch), 8'h20);
            wait_clear(ch, 8'h20);
            rdchk(ctl(ch), {2'(rates[k]), 6'h00}, "rate field");
            chk_val(baud_div[ch], 16'(exp_div(rates[k])), "divider");
            if (rates[k] != 0) rdchk(8'(`CQC_ADDR_PERIOD_A + ch), dev_period[ch], "period");
            chk_val(16'(boosts[ch]), 16'(WAKE), "boost cycles");
            chk_val(16'(wakes[ch]), 16'(WAKE), "wake cycles");
            chk_val(16'(probes[ch]), 16'(rates[k] == 0 ? 3 : 4 - rates[k]), "probes");
            chk_val(16'(wakes[1 - ch] + probes[1 - ch]), 16'h0, "other channel");
            irq_walk();
         end
      end
      for (int ch = 0; ch < 2; ch++) begin
         zero_counts();
         wr(ctl(ch), 8'h10);
         wait_clear(ch, 8'h10);
         chk_val(16'(wakes[ch]), 16'(WAKE), "manual wake");
         chk_val(16'(boosts[ch]), 16'h0, "no boost");
         chk_val(16'(tx_mode[ch]), 16'h0, "receive after wake");
         rdchk(`CQC_ADDR_STATUS, 8'h40, "wake flag");
      end
      report_and_stop();
   end
endmodule : test_cqc_channel_ctl
